// file: rtl/serial_mem_access.sv
// Slave-side I2C access logic for a 512-byte serial memory
`timescale 1ns/1ps
module serial_mem_access #(
    parameter int ADDR_W = serial_mem_pkg::ADDR_W,
    parameter int DATA_W = serial_mem_pkg::DATA_W,
    parameter int DEPTH  = serial_mem_pkg::DEPTH
) (
    // Clock, reset, enable
    input  wire logic       sys_clk_i,
    input  wire logic       rstn_i,
    input  wire logic       ce_i,
    // I2C pins (sda output enable low while pulling low)
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n_o,
    // Straps
    input  wire logic [1:0] chip_select_pins_i,
    input  wire logic       wp_i,
    // Status
    output logic            busy_o
);
    // ********************************
    // Input synchronisers
    // ********************************
    logic [1:0] scl_s_r, sda_s_r;
    logic       scl_q_r, sda_q_r;
    logic [1:0] cs_s1_r, cs_s2_r;
    logic       wp_s1_r, wp_s2_r;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            cs_s1_r <= 2'h0;
            cs_s2_r <= 2'h0;
            wp_s1_r <= 1'b0;
            wp_s2_r <= 1'b0;
        end else if (ce_i) begin
            scl_s_r <= {scl_s_r[0], scl_i};
            sda_s_r <= {sda_s_r[0], sda_i};
            scl_q_r <= scl_s_r[1];
            sda_q_r <= sda_s_r[1];
            cs_s1_r <= chip_select_pins_i;
            cs_s2_r <= cs_s1_r;
            wp_s1_r <= wp_i;
            wp_s2_r <= wp_s1_r;
        end
    end

    logic scl, sda, scl_rise, scl_fall, start_det, stop_det;
    assign scl       = scl_s_r[1];
    assign sda       = sda_s_r[1];
    assign scl_rise  = ce_i & scl & ~scl_q_r;
    assign scl_fall  = ce_i & ~scl & scl_q_r;
    assign start_det = ce_i & scl & scl_q_r & sda_q_r & ~sda;
    assign stop_det  = ce_i & scl & scl_q_r & ~sda_q_r & sda;

    function automatic logic addr_match(input logic [7:0] b, input logic [1:0] cs);
        addr_match = (b[serial_mem_pkg::TYPE_HI:serial_mem_pkg::TYPE_LO] == serial_mem_pkg::DEVICE_TYPE)
                   && (b[serial_mem_pkg::SEL_HI:serial_mem_pkg::SEL_LO] == cs);
    endfunction : addr_match

    function automatic logic [8:0] addr_inc(input logic [8:0] a);
        addr_inc = (a == serial_mem_pkg::ADDR_LAST) ? serial_mem_pkg::ADDR_FIRST
                                                    : a + serial_mem_pkg::ADDR_ONE;
    endfunction : addr_inc

    // ********************************
    // Protocol engine
    // ********************************
    serial_mem_pkg::state_t state_r, state_nxt;
    logic [3:0]        bit_r, bit_nxt;
    logic [7:0]        shift_r, shift_nxt;
    logic [8:0]        addr_r, addr_nxt;
    logic              drive_r, drive_nxt;
    logic              sda_lo_r, sda_lo_nxt;
    logic              wr_en;
    logic [7:0]        rd_data;
    logic [7:0]        rx_byte;

    assign rx_byte = {shift_r[6:0], sda};

    always_comb begin
        state_nxt  = state_r;
        bit_nxt    = bit_r;
        shift_nxt  = shift_r;
        addr_nxt   = addr_r;
        drive_nxt  = drive_r;
        sda_lo_nxt = sda_lo_r;
        wr_en      = 1'b0;
        if (stop_det) begin
            state_nxt  = serial_mem_pkg::ST_IDLE;
            sda_lo_nxt = 1'b0;
        end else if (start_det) begin
            state_nxt  = serial_mem_pkg::ST_SLAVE;
            // The SCL fall that closes the START carries no bit
            bit_nxt    = serial_mem_pkg::BIT_START;
            sda_lo_nxt = 1'b0;
        end else if (state_r != serial_mem_pkg::ST_IDLE) begin
            // Read byte shifts out on falls only; sampling would corrupt it
            if (scl_rise && bit_r <= serial_mem_pkg::BIT_LAST && state_r != serial_mem_pkg::ST_RDATA) begin
                shift_nxt = rx_byte;
            end
            if (scl_fall) begin
                bit_nxt = bit_r + 4'h1;
                if (bit_r == serial_mem_pkg::BIT_LAST) begin
                    sda_lo_nxt = 1'b0;
                    unique case (state_r)
                        serial_mem_pkg::ST_SLAVE: begin
                            sda_lo_nxt = addr_match(shift_r, cs2());
                            if (sda_lo_nxt) begin
                                addr_nxt[8] = shift_r[serial_mem_pkg::PAGE_BIT];
                                drive_nxt   = shift_r[serial_mem_pkg::RW_BIT];
                            end else begin
                                state_nxt = serial_mem_pkg::ST_IDLE;
                            end
                        end
                        serial_mem_pkg::ST_WORD: begin
                            addr_nxt[7:0] = shift_r;
                            sda_lo_nxt    = 1'b1;
                        end
                        serial_mem_pkg::ST_WDATA: begin
                            if (!wp_s2_r) begin
                                wr_en      = 1'b1;
                                addr_nxt   = addr_inc(addr_r);
                                sda_lo_nxt = 1'b1;
                            end
                        end
                        serial_mem_pkg::ST_RDATA: begin
                            addr_nxt = addr_inc(addr_r);
                        end
                        default: begin
                            sda_lo_nxt = 1'b0;
                        end
                    endcase
                end else if (bit_r == serial_mem_pkg::BIT_ACK) begin
                    bit_nxt    = 4'h0;
                    sda_lo_nxt = 1'b0;
                    unique case (state_r)
                        serial_mem_pkg::ST_SLAVE: begin
                            state_nxt = drive_r ? serial_mem_pkg::ST_RDATA : serial_mem_pkg::ST_WORD;
                            if (drive_r) begin
                                sda_lo_nxt = ~rd_data[7];
                                shift_nxt  = {rd_data[6:0], 1'b0};
                            end
                        end
                        serial_mem_pkg::ST_WORD, serial_mem_pkg::ST_WDATA: begin
                            state_nxt = serial_mem_pkg::ST_WDATA;
                        end
                        serial_mem_pkg::ST_RDATA: begin
                            if (sda) begin
                                state_nxt = serial_mem_pkg::ST_IDLE;
                            end else begin
                                sda_lo_nxt = ~rd_data[7];
                                shift_nxt  = {rd_data[6:0], 1'b0};
                            end
                        end
                        default: begin
                            state_nxt = serial_mem_pkg::ST_IDLE;
                        end
                    endcase
                end else if (state_r == serial_mem_pkg::ST_RDATA) begin
                    sda_lo_nxt = ~shift_r[7];
                    shift_nxt  = {shift_r[6:0], 1'b0};
                end
            end
        end
    end

    // Select straps sampled two stages deep, never the raw pins
    function automatic logic [1:0] cs2();
        cs2 = cs_s2_r;
    endfunction : cs2

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r  <= serial_mem_pkg::ST_IDLE;
            bit_r    <= 4'h0;
            shift_r  <= 8'h00;
            addr_r   <= serial_mem_pkg::ADDR_FIRST;
            drive_r  <= 1'b0;
            sda_lo_r <= 1'b0;
        end else if (ce_i) begin
            state_r  <= state_nxt;
            bit_r    <= bit_nxt;
            shift_r  <= shift_nxt;
            addr_r   <= addr_nxt;
            drive_r  <= drive_nxt;
            sda_lo_r <= sda_lo_nxt;
        end
    end

    // ********************************
    // Pin and status registers
    // ********************************
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sda_o      <= 1'b1;
            sda_oe_n_o <= 1'b1;
            busy_o     <= 1'b0;
        end else if (ce_i) begin
            sda_o      <= 1'b0;
            sda_oe_n_o <= ~sda_lo_nxt;
            busy_o     <= state_nxt != serial_mem_pkg::ST_IDLE;
        end
    end

    // ********************************
    // Storage
    // ********************************
    // Read port always looks at the live address so data is ready one bit ahead, by the acknowledge fall
    serial_mem_array #(
        .ADDR_W (ADDR_W),
        .DATA_W (DATA_W),
        .DEPTH  (DEPTH)
    ) u_array (
        .sys_clk_i (sys_clk_i),
        .ce_i      (ce_i),
        .wr_en_i   (wr_en),
        .wr_addr_i (addr_r),
        .wr_data_i (shift_r),
        .rd_addr_i (addr_r),
        .rd_data_o (rd_data)
    );

    // ********************************
    // Assertions
    // ********************************
    AST_PROT_NO_WRITE: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        wr_en |-> !wp_s2_r) else $error("Write while protected");
    AST_PROT_ADDR_HOLD: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (ce_i && state_r == serial_mem_pkg::ST_WDATA && wp_s2_r && !stop_det && !start_det)
        |=> $stable(addr_r)) else $error("Address moved on protected write");
    // Bus let go and engine parked; both must hold after a STOP, a read NACK or a foreign type byte
    sequence idle_released_s;
        state_r == serial_mem_pkg::ST_IDLE ##1 sda_oe_n_o;
    endsequence : idle_released_s

    sequence drive_msb_s;
        state_r == serial_mem_pkg::ST_RDATA && sda_oe_n_o == $past(rd_data[7]);
    endsequence : drive_msb_s

    AST_STOP_IDLE: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        stop_det |=> idle_released_s) else $error("Stop did not release");
    AST_WRAP: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (wr_en && addr_r == serial_mem_pkg::ADDR_LAST) |=> addr_r == serial_mem_pkg::ADDR_FIRST)
        else $error("Address did not wrap");
    AST_WRITE_ACK: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        wr_en |=> !sda_oe_n_o) else $error("Written byte not acknowledged");
    AST_NOMATCH_QUIET: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        state_r == serial_mem_pkg::ST_IDLE |=> sda_oe_n_o) else $error("Drove bus while idle");
    AST_START_SLAVE: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        start_det && !stop_det |=> state_r == serial_mem_pkg::ST_SLAVE && bit_r == serial_mem_pkg::BIT_START)
        else $error("Start not honoured");
    AST_NO_WRITE_EARLY: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        wr_en |-> bit_r == serial_mem_pkg::BIT_LAST) else $error("Write before eighth bit");

    AST_NACK_RELEASE: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (scl_fall && bit_r == serial_mem_pkg::BIT_ACK && state_r == serial_mem_pkg::ST_RDATA && sda)
        |=> idle_released_s) else $error("Nack did not end read");
    AST_WRONG_TYPE: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (scl_fall && bit_r == serial_mem_pkg::BIT_LAST && state_r == serial_mem_pkg::ST_SLAVE
         && shift_r[serial_mem_pkg::TYPE_HI:serial_mem_pkg::TYPE_LO] != serial_mem_pkg::DEVICE_TYPE)
        |=> idle_released_s) else $error("Foreign slave byte answered");
    AST_FIRST_BIT: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (scl_fall && bit_r == serial_mem_pkg::BIT_ACK && state_r == serial_mem_pkg::ST_SLAVE && drive_r)
        |=> drive_msb_s) else $error("Read data not started");
    AST_NEXT_BYTE: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (scl_fall && bit_r == serial_mem_pkg::BIT_ACK && state_r == serial_mem_pkg::ST_RDATA && !sda)
        |=> drive_msb_s) else $error("Next byte not started");
    AST_READ_WRAP: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (scl_fall && bit_r == serial_mem_pkg::BIT_LAST && state_r == serial_mem_pkg::ST_RDATA
         && addr_r == serial_mem_pkg::ADDR_LAST) |=> addr_r == serial_mem_pkg::ADDR_FIRST)
        else $error("Read address did not wrap");
    AST_WORD_LATCH: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (scl_fall && bit_r == serial_mem_pkg::BIT_LAST && state_r == serial_mem_pkg::ST_WORD)
        |=> addr_r[7:0] == $past(shift_r) && !sda_oe_n_o) else $error("Word address not taken");
endmodule : serial_mem_access

// file: rtl/serial_mem_pkg.sv
// Shared constants for the I2C serial memory access block
package serial_mem_pkg;
    localparam int       ADDR_W        = 9;
    localparam int       DATA_W        = 8;
    localparam int       DEPTH         = 512;
    localparam int       BIT_CNT_W     = 4;
    localparam logic [3:0] BIT_LAST    = 4'h7;
    localparam logic [3:0] BIT_ACK     = 4'h8;
    localparam logic [3:0] BIT_START   = 4'hF;
    localparam logic [8:0] ADDR_LAST   = 9'h1FF;
    localparam logic [8:0] ADDR_FIRST  = 9'h000;
    localparam logic [8:0] ADDR_ONE    = 9'h001;
    localparam logic [7:0] WORD_ZERO   = 8'h00;
    localparam logic [3:0] DEVICE_TYPE = 4'h5; // Arbitrary type code
    localparam int       TYPE_HI       = 7;
    localparam int       TYPE_LO       = 4;
    localparam int       SEL_HI        = 3;
    localparam int       SEL_LO        = 2;
    localparam int       PAGE_BIT      = 1;
    localparam int       RW_BIT        = 0;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_SLAVE = 3'b001,
        ST_WORD  = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100,
        ST_RACK  = 3'b101
    } state_t;
endpackage : serial_mem_pkg

// file: rtl/serial_mem_array.sv
// Byte-wide storage array with registered read data
`timescale 1ns/1ps
module serial_mem_array #(
    parameter int ADDR_W = 9,
    parameter int DATA_W = 8,
    parameter int DEPTH  = 512
) (
    // Clock
    input  wire logic              sys_clk_i,
    input  wire logic              ce_i,
    // Write port
    input  wire logic              wr_en_i,
    input  wire logic [ADDR_W-1:0] wr_addr_i,
    input  wire logic [DATA_W-1:0] wr_data_i,
    // Read port
    input  wire logic [ADDR_W-1:0] rd_addr_i,
    output logic      [DATA_W-1:0] rd_data_o
);
    // No reset: contents are nonvolatile by intent
    logic [DATA_W-1:0] mem [DEPTH];

    always_ff @(posedge sys_clk_i) begin
        if (ce_i) begin
            if (wr_en_i) begin
                mem[wr_addr_i] <= wr_data_i;
            end
            rd_data_o <= mem[rd_addr_i];
        end
    end
endmodule : serial_mem_array

// file: testbench/i2c_master_model.sv
// I2C bus master model driving the memory's serial pins
`timescale 1ns/1ps
module i2c_master_model #(
    parameter int HALF = 4
) (
    // Clock
    input  wire logic sys_clk_i,
    // Bus
    input  wire logic sda_bus_i,
    output logic      scl_o,
    output logic      sda_o
);
    // **************************************
    // Bus idles high; SCL stands still between frames
    // **************************************
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : wt

    // SDA moves only mid-low; no false START or STOP
    task automatic clk_bit(input logic b, output logic s);
        wt(HALF / 2);
        sda_o <= b;
        wt(HALF / 2);
        scl_o <= 1'b1;
        wt(HALF / 2);
        s = sda_bus_i;
        wt(HALF / 2);
        scl_o <= 1'b0;
    endtask : clk_bit

    task automatic start();
        wt(HALF / 2);
        sda_o <= 1'b1;
        wt(HALF / 2);
        scl_o <= 1'b1;
        wt(HALF / 2);
        sda_o <= 1'b0;
        wt(HALF / 2);
        scl_o <= 1'b0;
    endtask : start

    task automatic stop();
        wt(HALF / 2);
        sda_o <= 1'b0;
        wt(HALF / 2);
        scl_o <= 1'b1;
        wt(HALF / 2);
        sda_o <= 1'b1;
        wt(HALF);
    endtask : stop

    task automatic send_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(v[i], s);
        clk_bit(1'b1, s);
        ack = ~s;
    endtask : send_byte

    task automatic recv_byte(input logic ack, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            v[i] = s;
        end
        clk_bit(~ack, s);
    endtask : recv_byte
endmodule : i2c_master_model

// file: testbench/serial_mem_access_bench.sv
// Self-checking bench for the serial memory access block
`timescale 1ns/1ps
module serial_mem_access_bench;
    // **************************************
    // Signals
    // **************************************
    localparam logic [1:0] CS    = 2'h2;
    localparam int         LIMIT = 40000;
    logic       sys_clk  = 1'b0;
    logic       rstn     = 1'b0;
    logic       scl;
    logic       sda_m;
    logic       sda_o;
    logic       sda_oe_n;
    logic       busy;
    logic [1:0] cs_pins  = CS;
    logic       wp       = 1'b0;
    logic       a;
    logic       s;
    logic [7:0] d;
    int         fails    = 0;
    int         compares = 0;
    int         cycles   = 0;
    // Open drain: low wins, released line pulled up
    wire        sda_bus  = sda_m & (sda_oe_n | sda_o);

    always #50 sys_clk = ~sys_clk;

    serial_mem_access u_dut (.sys_clk_i(sys_clk), .rstn_i(rstn), .ce_i(1'b1), .scl_i(scl),
        .sda_i(sda_bus), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .chip_select_pins_i(cs_pins),
        .wp_i(wp), .busy_o(busy));
    i2c_master_model u_m (.sys_clk_i(sys_clk), .sda_bus_i(sda_bus), .scl_o(scl), .sda_o(sda_m));

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    function automatic logic [7:0] sel(input logic page, input logic rw);
        return {serial_mem_pkg::DEVICE_TYPE, CS, page, rw};
    endfunction : sel

    task automatic addr_set(input logic page, input logic [7:0] word);
        u_m.start();
        u_m.send_byte(sel(page, 1'b0), a);
        chk("write slave ack", {7'h00, a}, 8'h01);
        u_m.send_byte(word, a);
        chk("word ack", {7'h00, a}, 8'h01);
    endtask : addr_set

    task automatic rd_go(input logic page);
        u_m.start();
        u_m.send_byte(sel(page, 1'b1), a);
        chk("read slave ack", {7'h00, a}, 8'h01);
    endtask : rd_go

    task automatic wr_byte(input logic [7:0] v, input logic exp);
        u_m.send_byte(v, a);
        chk("data ack", {7'h00, a}, {7'h00, exp});
    endtask : wr_byte

    task automatic rd_byte(input logic ack, input logic [7:0] exp);
        u_m.recv_byte(ack, d);
        chk("read data", d, exp);
    endtask : rd_byte

    task automatic t_write_read();
        addr_set(1'b0, 8'h10);
        chk("busy", {7'h00, busy}, 8'h01);
        wr_byte(8'hA5, 1'b1);
        wr_byte(8'h3C, 1'b1);
        wr_byte(8'h5A, 1'b1);
        u_m.stop();
        addr_set(1'b0, 8'h10);
        rd_go(1'b0);
        rd_byte(1'b1, 8'hA5);
        rd_byte(1'b0, 8'h3C);
        u_m.stop();
    endtask : t_write_read

    task automatic t_protect();
        @(posedge sys_clk) wp <= 1'b1;
        addr_set(1'b0, 8'h10);
        wr_byte(8'h77, 1'b0);
        wr_byte(8'h66, 1'b0);
        u_m.stop();
        @(posedge sys_clk) wp <= 1'b0;
        rd_go(1'b0);
        rd_byte(1'b1, 8'hA5);
        rd_byte(1'b0, 8'h3C);
        u_m.stop();
    endtask : t_protect

    task automatic t_wrap();
        addr_set(1'b1, 8'hFF);
        wr_byte(8'h11, 1'b1);
        wr_byte(8'h22, 1'b1);
        u_m.stop();
        addr_set(1'b1, 8'hFF);
        rd_go(1'b1);
        rd_byte(1'b1, 8'h11);
        rd_byte(1'b0, 8'h22);
        u_m.stop();
        addr_set(1'b0, 8'h00);
        rd_go(1'b0);
        rd_byte(1'b0, 8'h22);
        u_m.stop();
    endtask : t_wrap

    task automatic t_abort();
        addr_set(1'b0, 8'h11);
        for (int i = 0; i < 7; i++) u_m.clk_bit(1'b0, s);
        u_m.stop();
        addr_set(1'b0, 8'h11);
        for (int i = 0; i < 7; i++) u_m.clk_bit(1'b1, s);
        rd_go(1'b0);
        rd_byte(1'b0, 8'h3C);
        u_m.stop();
    endtask : t_abort

    task automatic t_ends();
        addr_set(1'b0, 8'h10);
        rd_go(1'b0);
        for (int i = 0; i < 8; i++) u_m.clk_bit(1'b1, s);
        u_m.stop();
        repeat (8) @(posedge sys_clk);
        chk("released", {7'h00, sda_oe_n}, 8'h01);
        chk("busy", {7'h00, busy}, 8'h00);
        rd_go(1'b0);
        rd_byte(1'b0, 8'h3C);
        rd_go(1'b0);
        rd_byte(1'b0, 8'h5A);
        rd_byte(1'b0, 8'hFF);
        u_m.stop();
    endtask : t_ends

    task automatic t_nomatch();
        u_m.start();
        u_m.send_byte({serial_mem_pkg::DEVICE_TYPE, 2'h1, 2'h0}, a);
        chk("select mismatch ack", {7'h00, a}, 8'h00);
        u_m.send_byte(8'h00, a);
        chk("ignored ack", {7'h00, a}, 8'h00);
        u_m.start();
        u_m.send_byte({serial_mem_pkg::DEVICE_TYPE ^ 4'h1, CS, 2'h1}, a);
        chk("type mismatch ack", {7'h00, a}, 8'h00);
        u_m.stop();
    endtask : t_nomatch

    task automatic print_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fails++;
            print_verdict();
        end
    end

    initial begin
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_write_read();
        t_protect();
        t_wrap();
        t_abort();
        t_ends();
        t_nomatch();
        print_verdict();
    end
endmodule : serial_mem_access_bench
